// *** iodr_rec_asserts.sv ***
// Checker for the diagnostic record read port.
// Assumes it is bound onto iodr_record and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module iodr_rec_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Read request
  input wire logic rd_req,
  input wire logic [7:0] record_set_number,
  input wire logic [4:0] rd_offset,
  // Answer
  input wire logic rd_valid_r,
  input wire logic rd_err_r,
  input wire logic [7:0] rd_data_r,
  // Object indices
  input wire logic [15:0] can_index_full,
  input wire logic [15:0] ecat_index
);
  reg [13:0] p1, p2;
  // Cleared by reset: a read cut off by reset gets no answer
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) {p1, p2} <= 28'h0;
    else {p1, p2} <= {rd_req, record_set_number, rd_offset, p1};
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  answer_lat_a: assert property (rd_valid_r == p2[13]) else $error("answer timing wrong");
  class_byte_a: assert property (p2[13] && p2[12:5] < 8'h02 && p2[4:0] == 5'h01 |-> rd_data_r == 8'h1f)
    else $error("bad class byte");
  kind_byte_a: assert property (p2 == {1'b1, 8'h01, 5'h04} |-> rd_data_r == 8'h70) else $error("bad kind");
  diag_bits_a: assert property (p2 == {1'b1, 8'h01, 5'h05} |-> rd_data_r == 8'h00) else $error("bad bits");
  chan_count_a: assert property (p2 == {1'b1, 8'h01, 5'h06} |-> rd_data_r == 8'h04) else $error("bad count");
  bad_set_a: assert property (p2[13] && p2[12:5] > 8'h01 |-> rd_err_r && rd_data_r == 8'h00)
    else $error("bad set accepted");
  short_len_a: assert property (p2[13] && p2[12:5] == 8'h00 && p2[4:0] > 5'h03 |-> rd_err_r)
    else $error("short set overrun");
  fixed_index_a: assert property (can_index_full == 16'h2f01 && ecat_index == 16'h5005)
    else $error("bad object index");
endmodule // iodr_rec_asserts
bind iodr_record iodr_rec_asserts chk_i (.clk_sys, .resetn, .rd_req, .record_set_number, .rd_offset,
  .rd_valid_r, .rd_err_r, .rd_data_r, .can_index_full, .ecat_index);
`default_nettype wire

// *** iodr_record.v ***
// Diagnostic record of a four-channel digital input module.
// Assumes the coupler issues one byte read per cycle and asks for generation first.
`timescale 1ns/1ps
`default_nettype none
`include "iodr_regs.vh"
module iodr_record (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Ticker from the head module
  input wire [31:0] ticker_us,
  // Record access
  input wire gen_req,
  input wire rd_req,
  input wire [7:0] record_set_number,
  input wire [4:0] rd_offset,
  output reg rd_valid_r,
  output reg [7:0] rd_data_r,
  output reg rd_err_r,
  // Identity
  output wire [15:0] can_index_full,
  output wire [15:0] ecat_index
);
  // Read timing: the request is sampled at edge c0, where offset and checks are registered;
  // the answer registers load at c1, so rd_valid_r is seen high at edge c2.
  // Back-to-back requests stream one answer per cycle.

  // Read pipeline, stage 1
  reg [4:0] off_q_r;
  reg ok_q_r;
  reg stamp_q_r;
  reg rd_pend_r;
  // Next values of the answer registers
  reg [7:0] rd_data_nxt;
  reg rd_err_nxt;
  // Decode and datapath
  wire [7:0] stamp_byte;
  wire [7:0] fixed_byte;
  wire [1:0] stamp_sel;
  wire in_range;
  wire stamp_hit;

  // Only the two documented set numbers are served
  function set_known;
    input [7:0] set_num;
    begin
      if (set_num == `IODR_SET_FULL) begin
        set_known = 1'b1;
      end else if (set_num == `IODR_SET_SHORT) begin
        set_known = 1'b1;
      end else begin
        set_known = 1'b0;
      end
    end
  endfunction

  // Short set exposes only the first four bytes
  function [4:0] set_length;
    input [7:0] set_num;
    begin
      if (set_num == `IODR_SET_FULL) begin
        set_length = `IODR_FULL_LEN;
      end else begin
        set_length = `IODR_SHORT_LEN;
      end
    end
  endfunction

  // A refused read still takes its slot in the pipeline and answers with an error
  function offset_in_set;
    input [7:0] set_num;
    input [4:0] off;
    begin
      if (!set_known(set_num)) begin
        offset_in_set = 1'b0;
      end else begin
        offset_in_set = (off < set_length(set_num)); // [RQ8]
      end
    end
  endfunction

  function is_stamp;
    input [4:0] off;
    begin
      if ((off >= `IODR_OFF_STAMP0) && (off <= `IODR_OFF_STAMP3)) begin
        is_stamp = 1'b1;
      end else begin
        is_stamp = 1'b0;
      end
    end
  endfunction

  // Byte lane of the stamp, lowest offset holding the least significant byte
  function [1:0] stamp_lane;
    input [4:0] off;
    reg [4:0] rel;
    begin
      rel = off - `IODR_OFF_STAMP0;
      stamp_lane = rel[1:0];
    end
  endfunction

  // Constant bytes; every other offset outside the stamp bytes is reserved and reads 00h
  function [7:0] fixed_value;
    input [4:0] off;
    begin
      if (off == `IODR_OFF_CLASS) begin
        fixed_value = {`IODR_CLASS_RSVD, `IODR_CHINFO_ON, `IODR_CLASS_DIGITAL}; // [RQ1] [RQ2]
      end else if (off == `IODR_OFF_KIND) begin
        fixed_value = {`IODR_KIND_TOP, `IODR_KIND_DIGIN}; // [RQ3]
      end else if (off == `IODR_OFF_NBITS) begin
        fixed_value = `IODR_NBITS_VAL; // [RQ4]
      end else if (off == `IODR_OFF_NCH) begin
        fixed_value = `IODR_NCH_VAL; // [RQ5]
      end else begin
        fixed_value = `IODR_RSVD_VAL;
      end
    end
  endfunction

  assign can_index_full = `IODR_CAN_INDEX_FULL; // [RQ9]
  assign ecat_index = `IODR_ECAT_INDEX; // [RQ10]

  assign in_range = offset_in_set(record_set_number, rd_offset); // [RQ8]
  assign stamp_hit = is_stamp(rd_offset);
  assign fixed_byte = fixed_value(off_q_r);
  // The stamp byte register loads on the request edge, so it indexes by the live offset;
  // a capture on that same edge is seen only by later reads
  assign stamp_sel = stamp_lane(rd_offset);

  iodr_stamp u_stamp (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .capture(gen_req),
    .ticker_us(ticker_us),
    .byte_sel(stamp_sel),
    .byte_data_r(stamp_byte)
  );

  // Stage 1: offset kept for the constant-byte decode
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      off_q_r <= `IODR_OFF_ERR_A;
    end else if (rd_req) begin
      off_q_r <= rd_offset;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ok_q_r <= 1'b0;
    end else begin
      ok_q_r <= rd_req & in_range;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stamp_q_r <= 1'b0;
    end else begin
      stamp_q_r <= rd_req & stamp_hit;
    end
  end

  // Marks that an answer is due on the next edge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_req;
    end
  end

  // Refused reads answer with the error flag and a zero byte
  always @* begin
    rd_err_nxt = 1'b0;
    if (rd_pend_r) begin
      rd_err_nxt = ~ok_q_r; // [RQ8]
    end
  end

  // Data holds between answers so the coupler may sample it late
  always @* begin
    rd_data_nxt = rd_data_r;
    if (rd_pend_r) begin
      if (!ok_q_r) begin
        rd_data_nxt = `IODR_RSVD_VAL;
      end else if (stamp_q_r) begin
        rd_data_nxt = stamp_byte; // [RQ6]
      end else begin
        rd_data_nxt = fixed_byte;
      end
    end
  end

  // Stage 2: the answer is only ever a reply to a read; no event output exists
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_pend_r; // [RQ11]
    end
  end

  // Error flag stands for the answer cycle only
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_err_r <= 1'b0;
    end else begin
      rd_err_r <= rd_err_nxt;
    end
  end

  // Read data register
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data_r <= `IODR_RSVD_VAL;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end
endmodule // iodr_record
`default_nettype wire

// *** iodr_record_tb.sv ***
// Self-checking bench for the diagnostic record.
// Assumes the ticker model stands in for the head module.
`timescale 1ns/1ps
`default_nettype none
module iodr_record_tb;
  logic clk_sys = 0, resetn = 0, gen_req = 0, rd_req = 0;
  logic [7:0] record_set_number = 8'h00;
  logic [4:0] rd_offset = 5'h00;
  logic [31:0] stamp = 32'h0;
  wire [31:0] ticker_us;
  wire rd_valid_r, rd_err_r;
  wire [7:0] rd_data_r;
  wire [15:0] can_index_full, ecat_index;
  int num_errors = 0, checks_done = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  iodr_ticker_model model (.clk_sys(clk_sys), .resetn(resetn), .ticker_us(ticker_us));
  iodr_record dut (.clk_sys(clk_sys), .resetn(resetn), .ticker_us(ticker_us), .gen_req(gen_req),
    .rd_req(rd_req), .record_set_number(record_set_number), .rd_offset(rd_offset), .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r), .rd_err_r(rd_err_r), .can_index_full(can_index_full), .ecat_index(ecat_index));
  function automatic logic [8:0] exp_byte(input logic [7:0] s, input logic [4:0] o, input logic [31:0] st);
    if (s > 8'h01 || o >= (s == 8'h00 ? 5'h04 : 5'h14)) return 9'h100;
    case (o)
      5'h01: return 9'h01f;
      5'h04: return 9'h070;
      5'h06: return 9'h004;
      5'h10, 5'h11, 5'h12, 5'h13: return {1'b0, st[8 * (o - 5'h10) +: 8]};
      default: return 9'h000;
    endcase
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rd(input logic [7:0] s, input logic [4:0] o);
    @(negedge clk_sys);
    rd_req = 1;
    record_set_number = s;
    rd_offset = o;
    @(negedge clk_sys);
    rd_req = 0;
    // The answer stands for one cycle only, between the second and third rising edge
    @(negedge clk_sys);
    chk({22'h0, rd_valid_r, rd_err_r, rd_data_r}, {22'h0, 1'b1, exp_byte(s, o, stamp)});
  endtask
  // Ticker is stable at the falling edge, so this is what the next rising edge captures
  task gen;
    @(negedge clk_sys);
    gen_req = 1;
    stamp = ticker_us;
    @(negedge clk_sys);
    gen_req = 0;
  endtask
  task give_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1c3efbde));
    repeat (8) @(negedge clk_sys);
    resetn = 1;
    rd(8'h01, 5'h13);
    chk({can_index_full, ecat_index}, 32'h2f01_5005);
    gen;
    for (int s = 0; s < 3; s++) for (int o = 0; o < 32; o++) rd(s[7:0], o[4:0]);
    rd(8'hff, 5'h01);
    repeat (60) begin
      if ($urandom % 4 == 0) gen;
      rd(8'($urandom % 3), 5'($urandom % 4 + 16));
    end
    @(negedge clk_sys) resetn = 0;
    @(negedge clk_sys) resetn = 1;
    stamp = 32'h0;
    rd(8'h01, 5'h10);
    give_verdict;
  end
endmodule // iodr_record_tb
`default_nettype wire

// *** iodr_regs.vh ***
// Constants for the diagnostic record of a four-channel digital input module.
// Assumes a byte-wide record read interface from the backplane bus controller.
// Function
// RQ1: Module class byte low four bits read 1111b, digital module; bits 7..5 reserved.
// RQ2: Module class bit 4 flags that per-channel information is present.
// RQ3: Channel kind byte reads 70h in bits 6..0; bit 7 reads zero.
// RQ4: Diagnostic bits per channel byte reads 00h.
// RQ5: Channel count byte reads 04h.
// RQ6: Timestamp bytes 0..3 hold microsecond ticker sampled at record generation.
// RQ7: All four timestamp bytes are captured in one clock cycle.
// RQ8: Full record read as set 01h; first four bytes also as set 00h.
// RQ9: Over CANopen the full record sits at object index 2F01h.
// RQ10: Over the Ethernet fieldbus fields are subindices of object 5005h.
// RQ11: Module raises no interrupts; record is read on demand only.
`ifndef IODR_REGS_VH
`define IODR_REGS_VH

// Record set numbers
`define IODR_SET_SHORT 8'h00
`define IODR_SET_FULL 8'h01
`define IODR_SHORT_LEN 5'h04
`define IODR_FULL_LEN 5'h14

// Byte offsets inside the record
`define IODR_OFF_ERR_A 5'h00
`define IODR_OFF_CLASS 5'h01
`define IODR_OFF_ERR_C 5'h02
`define IODR_OFF_ERR_D 5'h03
`define IODR_OFF_KIND 5'h04
`define IODR_OFF_NBITS 5'h05
`define IODR_OFF_NCH 5'h06
`define IODR_OFF_RESERVED_CHANNEL_ERROR 5'h07
`define IODR_OFF_RESERVED_PER_CHANNEL_ERROR_LO 5'h08
`define IODR_OFF_RESERVED_PER_CHANNEL_ERROR_HI 5'h0f
`define IODR_OFF_STAMP0 5'h10
`define IODR_OFF_STAMP3 5'h13

// Field values
`define IODR_CLASS_DIGITAL 4'hf
`define IODR_CHINFO_BIT 4
`define IODR_KIND_DIGIN 7'h70
`define IODR_NBITS_VAL 8'h00
`define IODR_NCH_VAL 8'h04
`define IODR_RSVD_VAL 8'h00
`define IODR_CLASS_RSVD 3'h0
`define IODR_CHINFO_ON 1'h1
`define IODR_KIND_TOP 1'h0

// Fieldbus addressing handed to the coupler
`define IODR_CAN_INDEX_FULL 16'h2f01
`define IODR_CAN_INDEX_SHORT 16'h2f00
`define IODR_ECAT_INDEX 16'h5005

`endif

// *** iodr_stamp.v ***
// Four-byte timestamp holder for the diagnostic record.
// Assumes the ticker input is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module iodr_stamp (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Capture
  input wire capture,
  input wire [31:0] ticker_us,
  // Byte read
  input wire [1:0] byte_sel,
  output reg [7:0] byte_data_r
);
  reg [31:0] stamp_r;

  // One wide load keeps a multi-byte read coherent
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stamp_r <= 32'h00000000;
    end else if (capture) begin
      stamp_r <= ticker_us; // [RQ6] [RQ7]
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      byte_data_r <= 8'h00;
    end else begin
      byte_data_r <= stamp_r[{byte_sel, 3'h0} +: 8];
    end
  end
endmodule // iodr_stamp
`default_nettype wire

// *** iodr_ticker_model.sv ***
// Head-module microsecond ticker that feeds the record.
// Assumes a step of 0101_0101h per clk_sys cycle to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module iodr_ticker_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Ticker
  output logic [31:0] ticker_us
);
  // Every byte moves each cycle so a torn capture shows up
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) ticker_us <= 32'h8040_2010;
    else ticker_us <= ticker_us + 32'h0101_0101;
  end
endmodule // iodr_ticker_model
`default_nettype wire
